//--- mcad_core.sv
// Execution core: fetch/execute pipeline, decoder, registers, phases
`timescale 1ns/100ps
`include "mcad_map.svh"
module mcad_core import mcad_pkg::*; #(
	parameter int PROG_WORDS = 2048 // Program memory words
) (
	input wire logic CORE_CLK, // Oscillator input clock
	input wire logic RESET_N, // Master clear, active low
	input wire logic RESISTOR_CAPACITOR_OSC_MODE, // Resistor-capacitor mode
	output logic CYCLE_CLOCK_OUTPUT_PIN, // Quarter-rate cycle clock
	output logic [$clog2(PROG_WORDS)-1:0] PROG_ADDR, // Fetch address
	input wire logic [13:0] PROG_DATA, // Fetched instruction word
	output logic [7:0] FILE_ADDR, // Data memory address
	output logic FILE_RD_EN, // Data read strobe
	input wire logic [7:0] FILE_RDATA, // Data read value
	output logic FILE_WR_EN, // Data write strobe
	output logic [7:0] FILE_WDATA, // Data write value
	output logic OPERAND_READ_PHASE, // Second quarter
	output logic RESULT_WRITE_PHASE, // Fourth quarter
	output logic [12:0] PROGRAM_COUNTER, // Next fetch address
	output logic [7:0] STATUS_OUT, // Status register
	output logic [7:0] ACCUM_OUT // Working accumulator
);

	localparam int AW = $clog2(PROG_WORDS);
	localparam int SPW = $clog2(`MCAD_STACK_DEPTH);

	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	// internal memory size
	if (PROG_WORDS != 512 && PROG_WORDS != 2048) begin : g_bad_size
		$error("PROG_WORDS must be 512 or 2048");
	end

	mcad_phase_t phase_q;
	logic [12:0] pc_q;
	logic [12:0] fetch_addr_q;
	logic [13:0] ir_q;
	logic flush_q;
	logic [7:0] w_q;
	logic [7:0] status_q;
	logic [7:0] fsr_q;
	logic [4:0] pclath_q;
	logic [12:0] stack_q [`MCAD_STACK_DEPTH];
	logic [SPW-1:0] sp_q;
	logic [7:0] file_addr_q;
	logic [7:0] operand_q;
	logic [7:0] result_q;
	logic carry_q;
	logic dcarry_q;
	logic zero_q;
	logic take_q;
	logic cko_q;
	mcad_alu_op_t alu_op;
	mcad_flow_t flow;
	logic use_lit;
	logic to_w;
	logic to_f;
	logic need_rd;
	logic fl_z;
	logic fl_c;
	logic fl_dc;
	logic exec_ok;
	logic sfr_hit;
	logic [7:0] sfr_rdata;
	logic [7:0] alu_res;
	logic alu_c;
	logic alu_dc;
	logic alu_z;
	logic take;
	logic [7:0] status_d;
	logic [6:0] f_low;

	assign exec_ok = ~flush_q;
	assign f_low = file_addr_q[6:0];

	// ------------------------------------------------------------------
	// Quarter phase sequencer
	// ------------------------------------------------------------------
	// four quarters per cycle
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			phase_q <= PH_Q1;
		end else begin
			case (phase_q)
				PH_Q1: phase_q <= PH_RD;
				PH_RD: phase_q <= PH_Q3;
				PH_Q3: phase_q <= PH_WR;
				PH_WR: phase_q <= PH_Q1;
				default: phase_q <= PH_Q1;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Instruction decode
	// ------------------------------------------------------------------
	// two-operand source select
	always_comb begin
		alu_op = ALU_PASS_B;
		flow = FLOW_NEXT;
		use_lit = 1'b0;
		to_w = 1'b0;
		to_f = 1'b0;
		need_rd = 1'b0;
		fl_z = 1'b0;
		fl_c = 1'b0;
		fl_dc = 1'b0;
		case (ir_q[13:12])
			`MCAD_CLS_BYTE: begin
				need_rd = 1'b1;
				to_w = ~ir_q[7];
				to_f = ir_q[7];
				fl_z = 1'b1;
				case (ir_q[11:8])
					`MCAD_B_ADD: begin
						alu_op = ALU_ADD;
						fl_c = 1'b1;
						fl_dc = 1'b1;
					end
					`MCAD_B_SUB: begin
						alu_op = ALU_SUB;
						fl_c = 1'b1;
						fl_dc = 1'b1;
					end
					`MCAD_B_AND: alu_op = ALU_AND;
					`MCAD_B_IOR: alu_op = ALU_OR;
					`MCAD_B_XOR: alu_op = ALU_XOR;
					`MCAD_B_CLR: begin
						alu_op = ALU_ZERO;
						need_rd = 1'b0;
					end
					`MCAD_B_COM: alu_op = ALU_COM;
					`MCAD_B_DEC: alu_op = ALU_DEC;
					`MCAD_B_INC: alu_op = ALU_INC;
					`MCAD_B_MOV: alu_op = ALU_PASS_B;
					`MCAD_B_DECSKIP: begin
						alu_op = ALU_DEC;
						fl_z = 1'b0;
						flow = FLOW_SKIP_ZERO;
					end
					`MCAD_B_INCSKIP: begin
						alu_op = ALU_INC;
						fl_z = 1'b0;
						flow = FLOW_SKIP_ZERO;
					end
					`MCAD_B_RL: begin
						alu_op = ALU_RL;
						fl_z = 1'b0;
						fl_c = 1'b1;
					end
					`MCAD_B_RR: begin
						alu_op = ALU_RR;
						fl_z = 1'b0;
						fl_c = 1'b1;
					end
					`MCAD_B_SWAP: begin
						alu_op = ALU_SWAP;
						fl_z = 1'b0;
					end
					default: begin
						// Accumulator store, or no-operation and returns
						alu_op = ALU_PASS_A;
						need_rd = 1'b0;
						fl_z = 1'b0;
						to_w = 1'b0;
						if (ir_q == `MCAD_RETURN_WORD ||
								ir_q == `MCAD_RETFIE_WORD) begin
							flow = FLOW_RET;
						end
					end
				endcase
			end
			`MCAD_CLS_BIT: begin
				need_rd = 1'b1;
				case (ir_q[11:10])
					`MCAD_BIT_CLR: begin
						alu_op = ALU_BCLR;
						to_f = 1'b1;
					end
					`MCAD_BIT_SET: begin
						alu_op = ALU_BSET;
						to_f = 1'b1;
					end
					`MCAD_BIT_SKIPCLR: flow = FLOW_SKIP_CLR;
					default: flow = FLOW_SKIP_SET;
				endcase
			end
			`MCAD_CLS_JUMP: flow = ir_q[11] ? FLOW_GOTO : FLOW_CALL;
			default: begin
				use_lit = 1'b1;
				to_w = 1'b1;
				casez (ir_q[11:8])
					`MCAD_L_MOV: alu_op = ALU_PASS_B;
					`MCAD_L_RET: flow = FLOW_RET;
					`MCAD_L_IOR: begin
						alu_op = ALU_OR;
						fl_z = 1'b1;
					end
					`MCAD_L_AND: begin
						alu_op = ALU_AND;
						fl_z = 1'b1;
					end
					`MCAD_L_XOR: begin
						alu_op = ALU_XOR;
						fl_z = 1'b1;
					end
					`MCAD_L_SUB: begin
						alu_op = ALU_SUB;
						{fl_z, fl_c, fl_dc} = 3'h7;
					end
					`MCAD_L_ADD: begin
						alu_op = ALU_ADD;
						{fl_z, fl_c, fl_dc} = 3'h7;
					end
					default: to_w = 1'b0;
				endcase
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Special registers in data space
	// ------------------------------------------------------------------
	// core registers mapped as files
	always_comb begin
		sfr_hit = 1'b1;
		case (f_low)
			`MCAD_ADR_INDIRECT: sfr_rdata = 8'h00;
			`MCAD_ADR_PCL: sfr_rdata = fetch_addr_q[7:0];
			`MCAD_ADR_STATUS: sfr_rdata = status_q;
			`MCAD_ADR_FSR: sfr_rdata = fsr_q;
			`MCAD_ADR_PCLATH: sfr_rdata = {3'h0, pclath_q};
			default: begin
				sfr_rdata = 8'h00;
				sfr_hit = 1'b0;
			end
		endcase
	end

	mcad_alu u_alu (
		.op(alu_op),
		.a(w_q),
		.b(operand_q),
		.carry_in(status_q[`MCAD_ST_C]),
		.bit_sel(ir_q[9:7]),
		.result(alu_res),
		.carry_out(alu_c),
		.digit_carry_out(alu_dc),
		.zero_out(alu_z)
	);

	// Branch decision from result or tested bit
	always_comb begin
		case (flow)
			FLOW_SKIP_ZERO: take = alu_z;
			FLOW_SKIP_CLR: take = ~operand_q[ir_q[9:7]];
			FLOW_SKIP_SET: take = operand_q[ir_q[9:7]];
			FLOW_GOTO, FLOW_CALL, FLOW_RET: take = 1'b1;
			default: take = to_f && sfr_hit && f_low == `MCAD_ADR_PCL;
		endcase
	end

	// ------------------------------------------------------------------
	// Operand path: address, then read, then compute
	// ------------------------------------------------------------------
	// direct or indirect on any file
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			file_addr_q <= 8'h00;
			operand_q <= 8'h00;
			result_q <= 8'h00;
			{carry_q, dcarry_q, zero_q, take_q} <= 4'h0;
		end else begin
			case (phase_q)
				PH_Q1: begin
					if (ir_q[6:0] == `MCAD_ADR_INDIRECT) begin
						file_addr_q <= fsr_q;
					end else begin
						file_addr_q <= {status_q[`MCAD_ST_RP0], ir_q[6:0]};
					end
				end
				PH_RD: begin
					if (use_lit) begin
						operand_q <= ir_q[7:0];
					end else if (sfr_hit) begin
						operand_q <= sfr_rdata;
					end else begin
						operand_q <= FILE_RDATA;
					end
				end
				PH_Q3: begin
					result_q <= alu_res;
					{carry_q, dcarry_q, zero_q} <= {alu_c, alu_dc, alu_z};
					take_q <= take & exec_ok;
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Accumulator, written in the write quarter
	// ------------------------------------------------------------------
	// accumulator outside data space
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			w_q <= `MCAD_W_RST;
		end else if (phase_q == PH_WR && exec_ok && to_w) begin
			w_q <= result_q;
		end
	end

	// Status next value: software write, then flag updates on top
	// flag update
	always_comb begin
		status_d = status_q;
		if (to_f && sfr_hit && f_low == `MCAD_ADR_STATUS) begin
			status_d = (status_q & ~`MCAD_STATUS_WMASK) |
				(result_q & `MCAD_STATUS_WMASK);
		end
		if (fl_c) status_d[`MCAD_ST_C] = carry_q;
		if (fl_dc) status_d[`MCAD_ST_DCARRY] = dcarry_q;
		if (fl_z) status_d[`MCAD_ST_Z] = zero_q;
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			status_q <= `MCAD_STATUS_RST;
			fsr_q <= `MCAD_FSR_RST;
			pclath_q <= `MCAD_PCLATH_RST;
		end else if (phase_q == PH_WR && exec_ok) begin
			status_q <= status_d;
			if (to_f && sfr_hit && f_low == `MCAD_ADR_FSR) begin
				fsr_q <= result_q;
			end
			if (to_f && sfr_hit && f_low == `MCAD_ADR_PCLATH) begin
				pclath_q <= result_q[4:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// Program counter and fetch, overlapped with execution
	// ------------------------------------------------------------------
	// fetch advances at Q1
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pc_q <= `MCAD_RESET_VECTOR;
			fetch_addr_q <= `MCAD_RESET_VECTOR;
		end else if (phase_q == PH_Q1) begin
			fetch_addr_q <= pc_q;
			pc_q <= pc_q + 13'h0001;
		end else if (phase_q == PH_WR && take_q) begin
			case (flow)
				FLOW_GOTO, FLOW_CALL: pc_q <= {pclath_q[4:3], ir_q[10:0]};
				FLOW_RET: pc_q <= stack_q[sp_q - 1'b1];
				FLOW_NEXT: pc_q <= {pclath_q, result_q};
				default: pc_q <= pc_q;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ir_q <= `MCAD_NOP_WORD;
			flush_q <= 1'b0;
		end else if (phase_q == PH_WR) begin
			ir_q <= PROG_DATA;
			flush_q <= take_q;
		end
	end

	// Return stack, circular, one entry per depth level
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			sp_q <= '0;
		end else if (phase_q == PH_WR && take_q) begin
			if (flow == FLOW_CALL) sp_q <= sp_q + 1'b1;
			if (flow == FLOW_RET) sp_q <= sp_q - 1'b1;
		end
	end

	for (genvar i = 0; i < `MCAD_STACK_DEPTH; i++) begin : g_stack
		always_ff @(posedge CORE_CLK or negedge RESET_N) begin
			if (!RESET_N) begin
				stack_q[i] <= `MCAD_RESET_VECTOR;
			end else if (phase_q == PH_WR && take_q && flow == FLOW_CALL &&
					sp_q == SPW'(i)) begin
				stack_q[i] <= fetch_addr_q;
			end
		end
	end

	// ------------------------------------------------------------------
	// Cycle clock output
	// ------------------------------------------------------------------
	// quarter-rate clock in RC mode
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cko_q <= 1'b0;
		end else begin
			cko_q <= RESISTOR_CAPACITOR_OSC_MODE &&
				(phase_q == PH_RD || phase_q == PH_Q3);
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign CYCLE_CLOCK_OUTPUT_PIN = cko_q;
	assign PROG_ADDR = fetch_addr_q[AW-1:0];
	assign FILE_ADDR = file_addr_q;
	assign FILE_RD_EN = phase_q == PH_RD && exec_ok && need_rd &&
		!use_lit && !sfr_hit;
	assign FILE_WR_EN = phase_q == PH_WR && exec_ok && to_f && !sfr_hit;
	assign FILE_WDATA = result_q;
	assign OPERAND_READ_PHASE = phase_q == PH_RD;
	assign RESULT_WRITE_PHASE = phase_q == PH_WR;
	assign PROGRAM_COUNTER = pc_q;
	assign STATUS_OUT = status_q;
	assign ACCUM_OUT = w_q;

endmodule

//--- mcad_map.svh
// Address map, field positions, encodings and timing counts of the core
`ifndef MCAD_MAP_SVH
`define MCAD_MAP_SVH

// ----------------------------------------------------------------------
// Core-held special registers (low seven address bits, both banks)
// ----------------------------------------------------------------------
`define MCAD_ADR_INDIRECT 7'h00
`define MCAD_ADR_PCL 7'h02
`define MCAD_ADR_STATUS 7'h03
`define MCAD_ADR_FSR 7'h04
`define MCAD_ADR_PCLATH 7'h0A

// ----------------------------------------------------------------------
// Status register fields and reset values
// ----------------------------------------------------------------------
`define MCAD_ST_C 0
`define MCAD_ST_DCARRY 1
`define MCAD_ST_Z 2
`define MCAD_ST_RP0 5
`define MCAD_STATUS_RST 8'h18
`define MCAD_STATUS_WMASK 8'hE7
`define MCAD_FSR_RST 8'h00
`define MCAD_PCLATH_RST 5'h00
`define MCAD_W_RST 8'h00

// ----------------------------------------------------------------------
// Program flow constants
// ----------------------------------------------------------------------
`define MCAD_PCNT_W 13
`define MCAD_RESET_VECTOR 13'h0000
`define MCAD_NOP_WORD 14'h0000
`define MCAD_RETURN_WORD 14'h0008
`define MCAD_RETFIE_WORD 14'h0009
`define MCAD_STACK_DEPTH 8

// ----------------------------------------------------------------------
// Instruction classes, byte-oriented and literal operation codes
// ----------------------------------------------------------------------
`define MCAD_CLS_BYTE 2'b00
`define MCAD_CLS_BIT 2'b01
`define MCAD_CLS_JUMP 2'b10
`define MCAD_CLS_LIT 2'b11
`define MCAD_B_MISC 4'h0
`define MCAD_B_CLR 4'h1
`define MCAD_B_SUB 4'h2
`define MCAD_B_DEC 4'h3
`define MCAD_B_IOR 4'h4
`define MCAD_B_AND 4'h5
`define MCAD_B_XOR 4'h6
`define MCAD_B_ADD 4'h7
`define MCAD_B_MOV 4'h8
`define MCAD_B_COM 4'h9
`define MCAD_B_INC 4'hA
`define MCAD_B_DECSKIP 4'hB
`define MCAD_B_RR 4'hC
`define MCAD_B_RL 4'hD
`define MCAD_B_SWAP 4'hE
`define MCAD_B_INCSKIP 4'hF
`define MCAD_BIT_CLR 2'b00
`define MCAD_BIT_SET 2'b01
`define MCAD_BIT_SKIPCLR 2'b10
`define MCAD_BIT_SKIPSET 2'b11
`define MCAD_L_MOV 4'b00??
`define MCAD_L_RET 4'b01??
`define MCAD_L_IOR 4'b1000
`define MCAD_L_AND 4'b1001
`define MCAD_L_XOR 4'b1010
`define MCAD_L_SUB 4'b110?
`define MCAD_L_ADD 4'b111?

// ----------------------------------------------------------------------
// Timing: oscillator periods per instruction cycle
// ----------------------------------------------------------------------
`define MCAD_CLK_PERIOD_NS 8
`define MCAD_QUARTERS 4
`define MCAD_CYCLE_NS (`MCAD_QUARTERS * `MCAD_CLK_PERIOD_NS)

`endif

//--- mcad_pkg.sv
// Types shared by the core and its arithmetic unit
package mcad_pkg;

	// Quarter phases of one instruction cycle
	typedef enum logic [1:0] {
		PH_Q1,
		PH_RD,
		PH_Q3,
		PH_WR
	} mcad_phase_t;

	// Arithmetic unit operations
	typedef enum logic [3:0] {
		ALU_PASS_B,
		ALU_PASS_A,
		ALU_ZERO,
		ALU_ADD,
		ALU_SUB,
		ALU_AND,
		ALU_OR,
		ALU_XOR,
		ALU_COM,
		ALU_INC,
		ALU_DEC,
		ALU_RL,
		ALU_RR,
		ALU_SWAP,
		ALU_BCLR,
		ALU_BSET
	} mcad_alu_op_t;

	// Program flow effect of an instruction
	typedef enum logic [2:0] {
		FLOW_NEXT,
		FLOW_SKIP_ZERO,
		FLOW_SKIP_CLR,
		FLOW_SKIP_SET,
		FLOW_GOTO,
		FLOW_CALL,
		FLOW_RET
	} mcad_flow_t;

endpackage

//--- mcad_alu.sv
// Eight-bit arithmetic and logic unit with carry, digit carry and zero
`timescale 1ns/100ps
module mcad_alu import mcad_pkg::*; (
	input wire mcad_alu_op_t op, // Operation select
	input wire logic [7:0] a, // Working accumulator operand
	input wire logic [7:0] b, // File register or literal operand
	input wire logic carry_in, // Current carry flag
	input wire logic [2:0] bit_sel, // Bit index for set and clear
	output logic [7:0] result, // Eight-bit result
	output logic carry_out, // Carry, or not-borrow on subtract
	output logic digit_carry_out, // Low nibble carry or not-borrow
	output logic zero_out // Result equals zero
);

	logic [8:0] sum9;
	logic [4:0] nib5;
	logic [7:0] mask;

	// ------------------------------------------------------------------
	// Operation decode
	// ------------------------------------------------------------------
	// eight-bit operations
	always_comb begin
		sum9 = 9'h000;
		nib5 = 5'h00;
		mask = 8'h01 << bit_sel;
		result = 8'h00;
		carry_out = carry_in;
		digit_carry_out = 1'b0;
		case (op)
			ALU_ADD: begin
				sum9 = {1'b0, a} + {1'b0, b};
				nib5 = {1'b0, a[3:0]} + {1'b0, b[3:0]};
				result = sum9[7:0];
				carry_out = sum9[8];
				digit_carry_out = nib5[4];
			end
			ALU_SUB: begin
				sum9 = {1'b0, b} + {1'b0, ~a} + 9'h001;
				nib5 = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
				result = sum9[7:0];
				carry_out = sum9[8];
				digit_carry_out = nib5[4];
			end
			ALU_PASS_A: result = a;
			ALU_ZERO: result = 8'h00;
			ALU_AND: result = a & b;
			ALU_OR: result = a | b;
			ALU_XOR: result = a ^ b;
			ALU_COM: result = ~b;
			ALU_INC: result = b + 8'h01;
			ALU_DEC: result = b - 8'h01;
			ALU_RL: begin
				result = {b[6:0], carry_in};
				carry_out = b[7];
			end
			ALU_RR: begin
				result = {carry_in, b[7:1]};
				carry_out = b[0];
			end
			ALU_SWAP: result = {b[3:0], b[7:4]};
			ALU_BCLR: result = b & ~mask;
			ALU_BSET: result = b | mask;
			default: result = b;
		endcase
	end

	// Zero detect on the eight-bit result
	// zero flag source
	assign zero_out = (result == 8'h00);

endmodule

//--- mcad_core_props.sv
// Port-level timing checks for the execution core
`timescale 1ns/100ps
`include "mcad_map.svh"
module mcad_core_props #(
	parameter int PROG_WORDS = 2048 // Program memory words
) (
	input wire logic CORE_CLK, // Clock
	input wire logic RESET_N, // Reset
	input wire logic RESISTOR_CAPACITOR_OSC_MODE, // Oscillator mode
	input wire logic CYCLE_CLOCK_OUTPUT_PIN, // Cycle clock
	input wire logic [$clog2(PROG_WORDS)-1:0] PROG_ADDR, // Fetch address
	input wire logic [7:0] FILE_ADDR, // Data address
	input wire logic FILE_RD_EN, // Read strobe
	input wire logic FILE_WR_EN, // Write strobe
	input wire logic OPERAND_READ_PHASE, // Second quarter
	input wire logic RESULT_WRITE_PHASE, // Fourth quarter
	input wire logic [7:0] STATUS_OUT, // Status
	input wire logic [7:0] ACCUM_OUT // Accumulator
);
	// ------------------------------------------------------------
	// Phase, strobe and hold checks
	// ------------------------------------------------------------
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);
	property p_rd_phase;
		FILE_RD_EN |-> OPERAND_READ_PHASE;
	endproperty
	a_rd_phase: assert property (p_rd_phase)
		else $error("read strobe outside read phase");
	property p_wr_phase;
		FILE_WR_EN |-> RESULT_WRITE_PHASE;
	endproperty
	a_wr_phase: assert property (p_wr_phase)
		else $error("write strobe outside write phase");
	property p_phase_seq;
		OPERAND_READ_PHASE |=> !RESULT_WRITE_PHASE ##1 RESULT_WRITE_PHASE;
	endproperty
	a_phase_seq: assert property (p_phase_seq)
		else $error("write phase not two clocks after read");
	property p_cycle_len;
		RESULT_WRITE_PHASE |=> !RESULT_WRITE_PHASE [*3] ##1 RESULT_WRITE_PHASE;
	endproperty
	a_cycle_len: assert property (p_cycle_len)
		else $error("instruction cycle not four clocks");
	property p_clk_out;
		RESISTOR_CAPACITOR_OSC_MODE && OPERAND_READ_PHASE |->
			!CYCLE_CLOCK_OUTPUT_PIN ##1 CYCLE_CLOCK_OUTPUT_PIN [*2]
			##1 !CYCLE_CLOCK_OUTPUT_PIN;
	endproperty
	a_clk_out: assert property (p_clk_out)
		else $error("cycle clock shape wrong");
	property p_clk_off;
		!RESISTOR_CAPACITOR_OSC_MODE && !$past(RESISTOR_CAPACITOR_OSC_MODE)
			|-> !CYCLE_CLOCK_OUTPUT_PIN;
	endproperty
	a_clk_off: assert property (p_clk_off)
		else $error("cycle clock runs outside resistor-capacitor mode");
	property p_prog_stand;
		OPERAND_READ_PHASE |=> $stable(PROG_ADDR) [*3];
	endproperty
	a_prog_stand: assert property (p_prog_stand)
		else $error("fetch address moved inside a cycle");
	property p_faddr_stand;
		OPERAND_READ_PHASE |=> $stable(FILE_ADDR) [*2];
	endproperty
	a_faddr_stand: assert property (p_faddr_stand)
		else $error("data address moved before write");
	property p_core_held;
		FILE_RD_EN || FILE_WR_EN |-> !(FILE_ADDR[6:0] inside
			{`MCAD_ADR_INDIRECT, `MCAD_ADR_PCL, `MCAD_ADR_STATUS,
			`MCAD_ADR_FSR, `MCAD_ADR_PCLATH});
	endproperty
	a_core_held: assert property (p_core_held)
		else $error("strobe on a core-held address");
	property p_state_upd;
		$changed(ACCUM_OUT) || $changed(STATUS_OUT) |->
			$past(RESULT_WRITE_PHASE);
	endproperty
	a_state_upd: assert property (p_state_upd)
		else $error("accumulator or status moved off write phase");
	// Main traffic kinds
	c_write: cover property (FILE_WR_EN);
	c_read: cover property (FILE_RD_EN);
	c_clk: cover property ($rose(CYCLE_CLOCK_OUTPUT_PIN));
endmodule
bind mcad_core mcad_core_props #(.PROG_WORDS(PROG_WORDS)) props_u (
	.CORE_CLK(CORE_CLK),
	.RESET_N(RESET_N),
	.RESISTOR_CAPACITOR_OSC_MODE(RESISTOR_CAPACITOR_OSC_MODE),
	.CYCLE_CLOCK_OUTPUT_PIN(CYCLE_CLOCK_OUTPUT_PIN),
	.PROG_ADDR(PROG_ADDR),
	.FILE_ADDR(FILE_ADDR),
	.FILE_RD_EN(FILE_RD_EN),
	.FILE_WR_EN(FILE_WR_EN),
	.OPERAND_READ_PHASE(OPERAND_READ_PHASE),
	.RESULT_WRITE_PHASE(RESULT_WRITE_PHASE),
	.STATUS_OUT(STATUS_OUT),
	.ACCUM_OUT(ACCUM_OUT)
);

//--- mcad_mem_model.sv
// Program memory and data file seen by the core
`timescale 1ns/100ps
module mcad_mem_model #(
	parameter int PROG_WORDS = 2048 // Program memory words
) (
	input wire logic clk, // Core clock
	input wire logic [$clog2(PROG_WORDS)-1:0] prog_addr, // Fetch address
	output logic [13:0] prog_data, // Instruction word
	input wire logic [7:0] file_addr, // Data address
	input wire logic file_rd_en, // Read strobe
	output logic [7:0] file_rdata, // Read data
	input wire logic file_wr_en, // Write strobe
	input wire logic [7:0] file_wdata // Write data
);
	logic [13:0] rom [PROG_WORDS];
	logic [7:0] ram [256];
	logic [7:0] last_q = 8'h00;
	assign prog_data = rom[prog_addr];
	// Released data bus shows the inverse of the last read
	assign file_rdata = file_rd_en ? ram[file_addr] : ~last_q;
	// Byte write at the end of the write phase
	always @(posedge clk) begin
		if (file_rd_en)
			last_q <= ram[file_addr];
		if (file_wr_en)
			ram[file_addr] <= file_wdata;
	end
endmodule

//--- mcad_core_tb.sv
// Self-checking bench for the execution core
`timescale 1ns/100ps
module mcad_core_tb;
	localparam int PW = 2048;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic mode = 1'b0;
	logic [10:0] pa;
	logic [13:0] pd;
	logic [12:0] pc;
	logic [7:0] fa, frdata, fwd, st, w;
	logic frd, fwr, rd_ph, wr_ph, cko;
	int err_total = 0;
	int num_checks = 0;
	logic [13:0] prog[$];

	// ------------------------------------------------------------
	// Clock, design and memory
	// ------------------------------------------------------------
	always #4 clk = ~clk;
	mcad_core #(.PROG_WORDS(PW)) dut_u (
		.CORE_CLK(clk), .RESET_N(rst_n), .RESISTOR_CAPACITOR_OSC_MODE(mode),
		.CYCLE_CLOCK_OUTPUT_PIN(cko), .PROG_ADDR(pa), .PROG_DATA(pd),
		.FILE_ADDR(fa), .FILE_RD_EN(frd), .FILE_RDATA(frdata),
		.FILE_WR_EN(fwr), .FILE_WDATA(fwd), .OPERAND_READ_PHASE(rd_ph),
		.RESULT_WRITE_PHASE(wr_ph), .PROGRAM_COUNTER(pc), .STATUS_OUT(st),
		.ACCUM_OUT(w)
	);
	mcad_mem_model #(.PROG_WORDS(PW)) mem_u (
		.clk(clk), .prog_addr(pa), .prog_data(pd), .file_addr(fa),
		.file_rd_en(frd), .file_rdata(frdata), .file_wr_en(fwr),
		.file_wdata(fwd)
	);

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		if (err_total == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Load program, reset five clocks, then run a number of clocks
	task automatic run(input int edges, input logic m);
		@(posedge clk);
		rst_n <= 1'b0;
		mode <= m;
		for (int i = 0; i < PW; i++)
			mem_u.rom[i] = 14'h0000;
		foreach (prog[i])
			mem_u.rom[i] = prog[i];
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (edges) @(posedge clk);
		#1;
	endtask
	// Load accumulator, apply one literal operation, check W and flags
	task automatic lit_pair(input logic [13:0] op, input logic [7:0] a, b,
		input logic [7:0] w_exp, input logic [2:0] f);
		prog = {14'h3000 | a, op | b, 14'h2802};
		run(24, 1'b0);
		chk(w, w_exp);
		chk(st[2:0], f);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic s_reset;
		prog = {14'h3042, 14'h2801};
		run(24, 1'b0);
		chk(w, 8'h42);
		@(posedge clk);
		rst_n <= 1'b0;
		#1;
		chk(w, 8'h00);
		chk(st, 8'h18);
		chk(pc, 13'h0000);
	endtask
	task automatic s_add;
		lit_pair(14'h3E00, 8'h0F, 8'h01, 8'h10, 3'b010);
		lit_pair(14'h3E00, 8'h10, 8'hF0, 8'h00, 3'b101);
		lit_pair(14'h3E00, 8'h7F, 8'h01, 8'h80, 3'b010);
	endtask
	task automatic s_sub;
		lit_pair(14'h3C00, 8'h05, 8'h03, 8'hFE, 3'b000);
		lit_pair(14'h3C00, 8'h01, 8'h01, 8'h00, 3'b111);
		lit_pair(14'h3C00, 8'h01, 8'h10, 8'h0F, 3'b001);
	endtask
	task automatic s_logic;
		lit_pair(14'h3900, 8'hF0, 8'h3C, 8'h30, 3'b000);
		lit_pair(14'h3800, 8'hF0, 8'h3C, 8'hFC, 3'b000);
		lit_pair(14'h3A00, 8'hF0, 8'h3C, 8'hCC, 3'b000);
		lit_pair(14'h3900, 8'hF0, 8'h0F, 8'h00, 3'b100);
	endtask
	// Direct and indirect file access, add to file, rotate through carry
	task automatic s_file;
		prog = {14'h305A, 14'h00A0, 14'h3011, 14'h07A0, 14'h3005, 14'h0084,
			14'h3081, 14'h0080, 14'h0D00, 14'h2809};
		run(48, 1'b0);
		chk(mem_u.ram[8'h20], 8'h6B);
		chk(mem_u.ram[8'h05], 8'h81);
		chk(w, 8'h02);
		chk(st[2:0], 3'b001);
	endtask
	// Branch to the next word: the prefetched copy must not run
	task automatic s_branch;
		prog = {14'h2801, 14'h3E01, 14'h2802};
		run(15, 1'b0);
		chk(w, 8'h00);
		@(posedge clk);
		#1;
		chk(w, 8'h01);
	endtask
	task automatic s_clock;
		int n;
		int k;
		prog = {14'h2800};
		run(8, 1'b1);
		k = 0;
		while (cko !== 1'b1 && k < 8) begin
			@(posedge clk);
			#1;
			k++;
		end
		if (k == 8) begin
			err_total++;
			$display("[ERR] %0t cycle clock stuck", $time);
		end
		n = 0;
		repeat (16) begin
			@(posedge clk);
			#1;
			if (cko === 1'b1)
				n++;
		end
		chk(16'(n), 16'h0008);
		run(8, 1'b0);
		n = 0;
		repeat (16) begin
			@(posedge clk);
			#1;
			if (cko !== 1'b0)
				n++;
		end
		chk(16'(n), 16'h0000);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		s_reset();
		s_add();
		s_sub();
		s_logic();
		s_file();
		s_branch();
		s_clock();
		give_verdict();
	end
endmodule
